// ===== rtl/cvo_consts.svh
/*
  Constants of the clocked video output block: timing counts and packet layout.
  Assumes inclusion by the package and the top module of the block only.
*/
// How it works
// - Blanking intervals and both sync pulses are added around the active picture
// - Control packets set the reported format, picture packets carry the pixels
// - Pixel values leave unchanged, same colour plane order as they came in
// - Each pixel beat carries red, green and blue side by side
// - Horizontal and vertical sync leave on their own dedicated wires
// - Pixels cross from the system clock into the pixel clock timing safely
// - No input is accepted until the go input starts the block
// - Width, height and interlace flag of incoming video are reported
// - A format change raises a sticky status interrupt when enabled
// - Pixels wait in a queue while the output is blanking
// - A full queue drops ready and the source must stall
// - Output is progressive RGB
`ifndef CVO_CONSTS_SVH
`define CVO_CONSTS_SVH
`define CVO_PLANE_W 8
`define CVO_PIX_W 24
`define CVO_H_ACTIVE 11'h400
`define CVO_H_SYNC_BEG 11'h418
`define CVO_H_SYNC_END 11'h4a0
`define CVO_H_TOTAL 11'h540
`define CVO_V_ACTIVE 10'h300
`define CVO_V_SYNC_BEG 10'h303
`define CVO_V_SYNC_END 10'h309
`define CVO_V_TOTAL 10'h326
`define CVO_TYPE_VIDEO 4'h0
`define CVO_TYPE_CTRL 4'hf
`endif

// ===== rtl/cvo_pkg.sv
/*
  Types of the clocked video output block.
  Assumes the constants header is reachable by its bare name.
*/
`include "cvo_consts.svh"
package cvo_pkg;
  typedef enum logic [2:0] {
    CVO_IDLE = 3'b000,
    CVO_CW = 3'b001,
    CVO_CH = 3'b010,
    CVO_CI = 3'b011,
    CVO_VID = 3'b100,
    CVO_SKIP = 3'b101
  } cvo_parse_t;

  typedef struct packed {
    logic sof;
    logic [`CVO_PIX_W-1:0] rgb;
  } cvo_entry_t;

  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic interlaced;
  } cvo_fmt_t;
endpackage

// ===== rtl/cvo_top.sv
/*
  Clocked video output: packetised RGB stream in, DVI style pixels and syncs out.
  Assumes the pixel clock arrives as a plain pin and is sampled on clk; the
  source honours ready with zero latency and sends a header beat with sop.
*/
`timescale 1ns/1ps
`include "cvo_consts.svh"
module cvo_top #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic irq_en,
  input wire logic irq_clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`CVO_PIX_W-1:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic pix_clk,
  output logic [`CVO_PIX_W-1:0] vid_data,
  output logic vid_de,
  output logic vid_hsync,
  output logic vid_vsync,
  output cvo_pkg::cvo_fmt_t fmt,
  output logic underflow,
  output logic status_irq
);
  // ----------------------------------------
  // Pixel clock sampling
  // ----------------------------------------
  logic pc1_r, pc2_r, pc3_r, pcs_r, pcs_nxt, pix_tick;
  always_comb begin
    pcs_nxt = (pc2_r == pc3_r) ? pc3_r : pcs_r;
    pix_tick = (pc2_r == pc3_r) && pc3_r && !pcs_r;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pc1_r <= 1'b0;
      pc2_r <= 1'b0;
      pc3_r <= 1'b0;
      pcs_r <= 1'b0;
    end else begin
      pc1_r <= pix_clk;
      pc2_r <= pc1_r;
      pc3_r <= pc2_r;
      pcs_r <= pcs_nxt;
    end
  end

  // ----------------------------------------
  // Packet parsing and status
  // ----------------------------------------
  cvo_pkg::cvo_parse_t st_r, st_nxt;
  cvo_pkg::cvo_fmt_t fmt_nxt;
  logic first_r, first_nxt, irq_nxt, acc, wr_en;
  cvo_pkg::cvo_entry_t wr_ent;
  assign acc = in_valid && in_ready;
  always_comb begin
    st_nxt = st_r;
    fmt_nxt = fmt;
    first_nxt = first_r;
    irq_nxt = status_irq;
    wr_en = 1'b0;
    wr_ent = '{sof: first_r, rgb: in_data};
    if (irq_clr) irq_nxt = 1'b0;
    if (acc) begin
      if (in_sop) begin
        if (in_data[3:0] == `CVO_TYPE_CTRL) st_nxt = cvo_pkg::CVO_CW;
        else if (in_data[3:0] == `CVO_TYPE_VIDEO) st_nxt = cvo_pkg::CVO_VID;
        else st_nxt = cvo_pkg::CVO_SKIP;
        first_nxt = 1'b1;
      end else begin
        case (st_r)
          cvo_pkg::CVO_CW: begin
            fmt_nxt.width = in_data[15:0];
            st_nxt = cvo_pkg::CVO_CH;
          end
          cvo_pkg::CVO_CH: begin
            fmt_nxt.height = in_data[15:0];
            st_nxt = cvo_pkg::CVO_CI;
          end
          cvo_pkg::CVO_CI: begin
            fmt_nxt.interlaced = in_data[0];
            st_nxt = cvo_pkg::CVO_SKIP;
          end
          cvo_pkg::CVO_VID: begin
            wr_en = 1'b1;
            first_nxt = 1'b0;
          end
          default: ;
        endcase
        if (in_eop) st_nxt = cvo_pkg::CVO_IDLE;
      end
    end
    // Set beats clear in the same cycle
    if (irq_en && fmt_nxt != fmt) irq_nxt = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= cvo_pkg::CVO_IDLE;
      fmt <= '0;
      first_r <= 1'b0;
      status_irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fmt <= fmt_nxt;
      first_r <= first_nxt;
      status_irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Pixel queue
  // ----------------------------------------
  cvo_pkg::cvo_entry_t mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rd_en, rdy_nxt;
  always_comb begin
    cnt_nxt = cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    // Registered ready leaves one slot of slack for the beat in flight
    rdy_nxt = go && (cnt_nxt <= (AW+1)'(DEPTH - 2));
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(wr_en);
      rp_r <= rp_r + AW'(rd_en);
      cnt_r <= cnt_nxt;
      in_ready <= rdy_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (wr_en) mem_r[wp_r] <= wr_ent;
  end

  // ----------------------------------------
  // Raster timing
  // ----------------------------------------
  logic [10:0] h_r, h_nxt;
  logic [9:0] v_r, v_nxt;
  logic active, run_r, run_nxt;
  logic [`CVO_PIX_W-1:0] dat_nxt;
  logic de_nxt, hs_nxt, vs_nxt, uf_nxt;
  cvo_pkg::cvo_entry_t head;
  assign head = mem_r[rp_r];
  assign active = (h_r < `CVO_H_ACTIVE) && (v_r < `CVO_V_ACTIVE);
  always_comb begin
    h_nxt = h_r;
    v_nxt = v_r;
    run_nxt = run_r;
    dat_nxt = vid_data;
    de_nxt = vid_de;
    hs_nxt = vid_hsync;
    vs_nxt = vid_vsync;
    uf_nxt = underflow;
    rd_en = 1'b0;
    if (pix_tick) begin
      h_nxt = (h_r == `CVO_H_TOTAL - 11'h001) ? 11'h000 : h_r + 11'h001;
      if (h_r == `CVO_H_TOTAL - 11'h001)
        v_nxt = (v_r == `CVO_V_TOTAL - 10'h001) ? 10'h000 : v_r + 10'h001;
      // Lock to the first pixel of a frame at the top left corner
      if (h_r == 11'h000 && v_r == 10'h000) run_nxt = (cnt_r != '0) && head.sof;
      // Unlocked, heads without sof are dropped so a frame start waits at the head for the corner
      if (!run_r && cnt_r != '0 && !head.sof) rd_en = 1'b1;
      de_nxt = active;
      dat_nxt = '0;
      // A corner head without sof ends the lock; it is still shown if already locked, else dropped
      if (active && (run_r || run_nxt)) begin
        if (cnt_r != '0) begin
          rd_en = 1'b1;
          dat_nxt = head.rgb;
        end else begin
          uf_nxt = 1'b1;
        end
      end
      hs_nxt = (h_r >= `CVO_H_SYNC_BEG) && (h_r < `CVO_H_SYNC_END);
      vs_nxt = (v_r >= `CVO_V_SYNC_BEG) && (v_r < `CVO_V_SYNC_END);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      h_r <= '0;
      v_r <= '0;
      run_r <= 1'b0;
      vid_data <= '0;
      vid_de <= 1'b0;
      vid_hsync <= 1'b0;
      vid_vsync <= 1'b0;
      underflow <= 1'b0;
    end else begin
      h_r <= h_nxt;
      v_r <= v_nxt;
      run_r <= run_nxt;
      vid_data <= dat_nxt;
      vid_de <= de_nxt;
      vid_hsync <= hs_nxt;
      vid_vsync <= vs_nxt;
      underflow <= uf_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_tick_active;
    pix_tick && active;
  endsequence
  AST_NO_READY_IDLE: assert property (@(posedge clk) disable iff (rst)
    !go |=> !in_ready) else $error("ready while stopped");
  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("queue overflow");
  AST_FULL_STALL: assert property (@(posedge clk) disable iff (rst)
    cnt_r >= (AW+1)'(DEPTH - 1) |-> !in_ready) else $error("ready with full queue");
  AST_DE_ACTIVE: assert property (@(posedge clk) disable iff (rst)
    pix_tick |=> vid_de == $past(active)) else $error("enable off raster");
  AST_HS_WIRE: assert property (@(posedge clk) disable iff (rst)
    pix_tick && h_r == `CVO_H_SYNC_BEG |=> vid_hsync) else $error("hsync missing");
  AST_BLANK_ZERO: assert property (@(posedge clk) disable iff (rst)
    pix_tick && !active |=> vid_data == '0 && !vid_de) else $error("data in blanking");
  AST_PASS_THRU: assert property (@(posedge clk) disable iff (rst)
    s_tick_active ##0 (rd_en && (run_r || run_nxt)) |=> vid_data == $past(head.rgb))
    else $error("pixel altered");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
    irq_en && fmt_nxt != fmt |=> status_irq) else $error("irq not set");
  AST_H_WRAP: assert property (@(posedge clk) disable iff (rst)
    h_r < `CVO_H_TOTAL && v_r < `CVO_V_TOTAL) else $error("raster out of range");
endmodule

// ===== tb/cvo_dvi_sink.sv
/*
  Pixel sink in place of the DVI transmitter; records the first output line.
  Assumes outputs settle within half a link clock after each tick.
*/
`timescale 1ns/1ps
module cvo_dvi_sink (
  input wire logic pix_clk,
  input wire logic [23:0] vid_data,
  input wire logic vid_de,
  input wire logic vid_hsync,
  input wire logic vid_vsync
);
  // ------------
  // Line capture
  // ------------
  int t = 0;
  int t0 = -1;
  int de_end = -1;
  int hs_on = -1;
  int hs_off = -1;
  int t_next = -1;
  int vs_hits = 0;
  logic de_q = 1'b0;
  logic hs_q = 1'b0;
  logic [23:0] px [0:1023];
  // Latch on the link edge, as the transmitter does
  always @(posedge pix_clk) begin
    if (vid_de && !de_q && t0 >= 0 && t_next < 0) t_next = t - t0;
    if (vid_de && !de_q && t0 < 0) t0 = t;
    if (t0 >= 0 && t - t0 < 1024) px[t - t0] = vid_data;
    if (t0 >= 0 && !vid_de && de_q && de_end < 0) de_end = t - t0;
    if (t0 >= 0 && vid_hsync && !hs_q && hs_on < 0) hs_on = t - t0;
    if (hs_on >= 0 && !vid_hsync && hs_q && hs_off < 0) hs_off = t - t0;
    if (vid_vsync) vs_hits++;
    de_q = vid_de;
    hs_q = vid_hsync;
    t = t + 1;
  end
endmodule

// ===== tb/tb_cvo_top.sv
/*
  Bench of the clocked video output: format report, flow control, one line out.
  Assumes the design and the pixel sink model are compiled first.
*/
`timescale 1ns/1ps
module tb_cvo_top;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, irq_en = 1'b0, irq_clr = 1'b0;
  logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, pix_clk = 1'b0, run = 1'b0;
  logic [23:0] in_data = 24'h0;
  logic [1:0] pdiv = 2'h0;
  logic in_ready, vid_de, vid_hsync, vid_vsync, underflow, status_irq;
  logic [23:0] vid_data;
  cvo_pkg::cvo_fmt_t fmt;
  int n_fail = 0;
  int n_compared = 0;
  int i;
  always #5 clk = ~clk;
  // Link clock of 80 ns, held still until the queue is primed
  always @(posedge clk) begin
    if (run) begin
      pdiv <= pdiv + 2'h1;
      if (pdiv == 2'h3) pix_clk <= ~pix_clk;
    end
  end
  cvo_top cvo_top_inst (.clk(clk), .rst(rst), .go(go), .irq_en(irq_en), .irq_clr(irq_clr),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
    .in_eop(in_eop), .pix_clk(pix_clk), .vid_data(vid_data), .vid_de(vid_de),
    .vid_hsync(vid_hsync), .vid_vsync(vid_vsync), .fmt(fmt), .underflow(underflow),
    .status_irq(status_irq));
  cvo_dvi_sink cvo_dvi_sink_inst (.pix_clk(pix_clk), .vid_data(vid_data), .vid_de(vid_de),
    .vid_hsync(vid_hsync), .vid_vsync(vid_vsync));
  // -----------------
  // Shared procedures
  // -----------------
  function automatic logic [23:0] px(input int n);
    return {n[7:0], n[9:2] ^ 8'h3c, ~n[7:0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Offer a beat and hold it until the edge that takes it
  task automatic send(input logic [23:0] d, input logic s, input logic e);
    int k;
    k = 0;
    in_valid <= 1'b1;
    in_data <= d;
    in_sop <= s;
    in_eop <= e;
    @(posedge clk);
    while (in_ready !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    // A beat never taken is a failure, not a silent drop
    if (in_ready !== 1'b1) n_fail++;
  endtask
  // Beat offered before go must stay waiting
  task automatic hold_off();
    in_valid <= 1'b1;
    in_sop <= 1'b1;
    in_data <= 24'h00000f;
    repeat (6) begin
      @(posedge clk);
      check(in_ready, 1'b0);
    end
  endtask
  task automatic ctrl(input logic [15:0] w, input logic [15:0] h, input logic il);
    send(24'h00000f, 1'b1, 1'b0);
    send({8'h0, w}, 1'b0, 1'b0);
    send({8'h0, h}, 1'b0, 1'b0);
    send({23'h0, il}, 1'b0, 1'b1);
    in_valid <= 1'b0;
    repeat (2) @(posedge clk);
    check(fmt, {w, h, il});
    check(status_irq, 1'b1);
    irq_clr <= 1'b1;
    @(posedge clk);
    irq_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check(status_irq, 1'b0);
  endtask
  // Packet of an unknown type is taken and dropped, format kept
  task automatic skip_pkt();
    send(24'h000005, 1'b1, 1'b0);
    send(24'h000123, 1'b0, 1'b0);
    send(24'h000001, 1'b0, 1'b1);
    in_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check(fmt, {16'h0400, 16'h0300, 1'b0});
    check(status_irq, 1'b0);
  endtask
  // Pixel clock still: the queue fills and ready drops
  task automatic fill_queue();
    send(24'h000000, 1'b1, 1'b0);
    for (i = 0; i < 15; i++) send(px(i), 1'b0, 1'b0);
    in_data <= px(15);
    repeat (6) begin
      @(posedge clk);
      check(in_ready, 1'b0);
    end
  endtask
  // Pixel clock runs: one locked line out, then the queue runs dry
  task automatic first_line();
    run <= 1'b1;
    for (i = 15; i < 1024; i++) send(px(i), 1'b0, i == 1023);
    in_valid <= 1'b0;
    for (i = 0; i < 14000 && cvo_dvi_sink_inst.t_next < 0; i++) @(posedge clk);
    check(cvo_dvi_sink_inst.de_end, 1024);
    check(cvo_dvi_sink_inst.hs_on, 1048);
    check(cvo_dvi_sink_inst.hs_off, 1184);
    check(cvo_dvi_sink_inst.t_next, 1344);
    check(cvo_dvi_sink_inst.vs_hits, 0);
    check(underflow, 1'b1);
    for (i = 0; i < 1024; i++) check(cvo_dvi_sink_inst.px[i], px(i));
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hold_off();
    go <= 1'b1;
    irq_en <= 1'b1;
    ctrl(16'h02d0, 16'h01e0, 1'b1);
    ctrl(16'h0400, 16'h0300, 1'b0);
    skip_pkt();
    fill_queue();
    first_line();
    wrap_up();
  end
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
endmodule
